// ---- hw/dir_home.sv ----
// Summary of operation
// - keep 4-bit state per shared granule
// - start coherence toward owner, else serve memory
// - local-only shared encodes as 0000
// - modified: ownership bit plus owner mask bit (no mask bit when local owns)
// - shared: ownership clear, one bit per sharer
// - rightmost bit ownership; others sharing mask
// - local element always counted as sharer
// - shared granule owned by home memory
// - no reliance on transaction arrival order
// - never drop accepted requests
// - input acceptance independent of output progress
// - read-for-ownership waits for colliding castout
// - castout has priority over other operations
// - fabric gives deadlock-free response-less topology
// - switches route in dimension order
module dir_home (
  dir_if.home link,                  // request and answer port
  input wire logic load_valid,       // write one directory entry directly
  input wire logic [3:0] load_addr,  // granule index for the load
  input wire logic [3:0] load_state, // state written by the load
  output logic illegal_seen,         // sticky: an illegal state was ever met
  output logic [3:0] busy_count      // granules currently modified remotely
);
  // one state word per granule; the reset value is local-only shared
  logic [dir_pkg::STATE_W-1:0] dir_q [dir_pkg::GRANULES];
  logic [dir_pkg::STATE_W-1:0] cur;
  logic [dir_pkg::STATE_W-1:0] nxt;
  logic own;
  logic [2:0] mask;
  logic mask_multi;
  logic illegal;
  logic [dir_pkg::PE_W-1:0] owner;
  logic take;
  // operation decode
  logic is_read;
  logic is_rfo;
  logic is_castout;
  logic is_done;
  logic pend_cur;
  logic [dir_pkg::GRANULES-1:0] pend_q;  // rfo waiting on castout, per granule
  logic [3:0] bit_of;
  // per-granule remote ownership and its population count
  logic [dir_pkg::GRANULES-1:0] remote_mod;
  logic [4:0] remote_cnt;

  // always ready: acceptance never waits on any answer path
  assign link.req_ready = 1'b1;
  // every offered request is taken and answered; none is discarded
  assign take = link.req_valid;

  // operation decode, shared by the update and the answer paths
  assign is_read = link.req_op == dir_pkg::OP_READ;
  assign is_rfo = link.req_op == dir_pkg::OP_READ_OWN;
  assign is_castout = link.req_op == dir_pkg::OP_CASTOUT;
  assign is_done = link.req_op == dir_pkg::OP_OWNER_DONE;

  // the stored state is read before this request changes it
  assign cur = dir_q[link.req_addr];
  assign pend_cur = pend_q[link.req_addr];
  assign own = cur[dir_pkg::OWN_BIT];
  assign mask = cur[3:1];
  // true when two or more mask bits are set
  assign mask_multi = (mask & (mask - 3'h1)) != 3'h0;
  // ownership with more than one mask bit is undefined
  assign illegal = own && mask_multi;

  // owner named by the mask of a modified state; no mask bit means local
  always_comb begin
    owner = 2'h0;
    if (cur[dir_pkg::MASK_PE1]) begin
      owner = 2'h1;
    end else if (cur[dir_pkg::MASK_PE2]) begin
      owner = 2'h2;
    end else if (cur[dir_pkg::MASK_PE3]) begin
      owner = 2'h3;
    end
  end

  // mask bit of the requesting element
  always_comb begin
    case (link.req_pe)
      2'd1: bit_of = 4'h1 << dir_pkg::MASK_PE1;
      2'd2: bit_of = 4'h1 << dir_pkg::MASK_PE2;
      2'd3: bit_of = 4'h1 << dir_pkg::MASK_PE3;
      default: bit_of = 4'h0; // local is implied, needs no bit
    endcase
  end

  // next directory state; order-free: each request uses only the stored state
  // an illegal state is never rewritten by a request, so the error stays visible
  always_comb begin
    nxt = cur;
    if (!illegal) begin
      case (link.req_op)
        dir_pkg::OP_READ: begin
          // a sharer joins the mask; an owned granule is left to its owner
          if (!own) begin
            nxt = cur | bit_of;
          end
        end
        dir_pkg::OP_READ_OWN: begin
          // a waiting rfo leaves the entry alone until a castout or done has landed
          if (!own && !pend_cur) begin
            nxt = bit_of | dir_pkg::ST_LOCAL_MOD;
          end
        end
        dir_pkg::OP_CASTOUT: begin
          // castout retires ownership at once, ahead of any waiting rfo
          nxt = dir_pkg::ST_LOCAL_SHARED;
        end
        default: begin
          // owner returned data: previous owner and local share
          if (own) begin
            nxt = cur & ~dir_pkg::ST_LOCAL_MOD;
          end
        end
      endcase
    end
  end

  // a load of the granule in the same cycle wins over the request's update;
  // the request is still answered from the state that it saw
  always_ff @(posedge link.ref_clk or negedge link.rstn) begin
    if (!link.rstn) begin
      for (int i = 0; i < dir_pkg::GRANULES; i++) begin
        dir_q[i] <= dir_pkg::ST_RESET;
      end
    end else begin
      if (take) begin
        dir_q[link.req_addr] <= nxt;
      end
      if (load_valid) begin
        dir_q[load_addr] <= load_state;
      end
    end
  end

  // rfo that met an owner waits until a castout or done of that granule lands
  // a load replaces the entry and with it any waiting rfo
  always_ff @(posedge link.ref_clk or negedge link.rstn) begin
    if (!link.rstn) begin
      pend_q <= '0;
    end else begin
      if (take) begin
        if (is_castout || is_done) begin
          pend_q[link.req_addr] <= 1'b0;
        end else if (is_rfo && own && !illegal) begin
          pend_q[link.req_addr] <= 1'b1;
        end
      end
      if (load_valid) begin
        pend_q[load_addr] <= 1'b0;
      end
    end
  end

  // answer register: one pulse per taken request, one cycle later
  always_ff @(posedge link.ref_clk or negedge link.rstn) begin
    if (!link.rstn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_from_memory <= 1'b0;
      link.rsp_need_owner <= 1'b0;
      link.rsp_error <= 1'b0;
      link.rsp_owner <= 2'h0;
      link.rsp_state <= 4'h0;
    end else begin
      link.rsp_valid <= take;
      link.rsp_error <= take && illegal;
      // shared means home memory holds the data; modified needs the owner
      link.rsp_from_memory <= take && !illegal && !own;
      // only a read or rfo needs the owner's data; castout and done bring it
      link.rsp_need_owner <= take && !illegal && own && (is_read || is_rfo);
      link.rsp_owner <= owner;
      link.rsp_state <= cur;
    end
  end

  // sticky until reset; nothing else clears it
  always_ff @(posedge link.ref_clk or negedge link.rstn) begin
    if (!link.rstn) begin
      illegal_seen <= 1'b0;
    end else if (take && illegal) begin
      illegal_seen <= 1'b1;
    end
  end

  // one flag per granule held by exactly one remote owner; illegal codes excluded
  for (genvar g = 0; g < dir_pkg::GRANULES; g++) begin : g_remote
    logic [2:0] m;
    assign m = dir_q[g][3:1];
    assign remote_mod[g] = dir_q[g][dir_pkg::OWN_BIT] && (m != 3'h0) &&
                           ((m & (m - 3'h1)) == 3'h0);
  end

  // sixteen granules would overflow the 4-bit count; it saturates rather than wraps
  assign remote_cnt = 5'($countones(remote_mod));

  // registered from the stored states, so it trails an update by one cycle
  always_ff @(posedge link.ref_clk or negedge link.rstn) begin
    if (!link.rstn) begin
      busy_count <= 4'h0;
    end else if (remote_cnt > 5'h0f) begin
      busy_count <= 4'hf;
    end else begin
      busy_count <= remote_cnt[3:0];
    end
  end
endmodule : dir_home

// ---- hw/dir_pkg.sv ----
package dir_pkg;
  localparam int STATE_W = 4;
  localparam int ADDR_W = 4;
  localparam int GRANULES = 16;
  localparam int PE_W = 2;
  localparam int OWN_BIT = 0;            // rightmost bit (bit 3 in msb-0 numbering)
  localparam int MASK_PE1 = 1;           // mask bit for element 1
  localparam int MASK_PE2 = 2;           // mask bit for element 2
  localparam int MASK_PE3 = 3;           // mask bit for element 3
  localparam logic [3:0] ST_LOCAL_SHARED = 4'h0;
  localparam logic [3:0] ST_LOCAL_MOD = 4'h1;
  localparam logic [3:0] ST_PE1_MOD = 4'h3;
  localparam logic [3:0] ST_PE2_MOD = 4'h5;
  localparam logic [3:0] ST_PE3_MOD = 4'h9;
  localparam logic [3:0] ST_RESET = 4'h0;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_READ_OWN = 2'h1,
    OP_CASTOUT = 2'h2,
    OP_OWNER_DONE = 2'h3
  } op_type;
endpackage : dir_pkg

// ---- hw/dir_if.sv ----
interface dir_if (
  input wire logic ref_clk,
  input wire logic rstn
);
  logic req_valid;
  logic req_ready;
  dir_pkg::op_type req_op;
  logic [dir_pkg::ADDR_W-1:0] req_addr;
  logic [dir_pkg::PE_W-1:0] req_pe;
  logic rsp_valid;
  logic rsp_from_memory;
  logic rsp_need_owner;
  logic rsp_error;
  logic [dir_pkg::PE_W-1:0] rsp_owner;
  logic [dir_pkg::STATE_W-1:0] rsp_state;
  modport home (
    input ref_clk, rstn, req_valid, req_op, req_addr, req_pe,
    output req_ready, rsp_valid, rsp_from_memory, rsp_need_owner, rsp_error, rsp_owner,
    rsp_state
  );
  modport remote (
    input ref_clk, rstn, req_ready, rsp_valid, rsp_from_memory, rsp_need_owner, rsp_error,
    rsp_owner, rsp_state,
    output req_valid, req_op, req_addr, req_pe
  );
endinterface : dir_if

// ---- hw/dir_remote.sv ----
module dir_remote (
  dir_if.remote link,                      // request and answer port
  input wire logic user_valid,             // user request strobe
  input wire dir_pkg::op_type user_op,     // operation
  input wire logic [3:0] user_addr,        // granule index
  input wire logic [1:0] user_pe,          // requesting element
  output logic user_ready,                 // request taken
  output logic done_valid,                 // answer pulse
  output logic done_memory,                // served from memory
  output logic done_owner,                 // owner must supply
  output logic done_error,                 // illegal state met
  output logic [1:0] done_owner_pe,        // owning element
  output logic [3:0] done_state            // state seen
);
  // single request source and no queue: a castout is never held behind another op
  assign user_ready = link.req_ready;
  assign link.req_valid = user_valid;
  assign link.req_op = user_op;
  assign link.req_addr = user_addr;
  assign link.req_pe = user_pe;

  always_ff @(posedge link.ref_clk or negedge link.rstn) begin
    if (!link.rstn) begin
      done_valid <= 1'b0;
      done_memory <= 1'b0;
      done_owner <= 1'b0;
      done_error <= 1'b0;
      done_owner_pe <= 2'h0;
      done_state <= 4'h0;
    end else begin
      done_valid <= link.rsp_valid;
      done_memory <= link.rsp_from_memory;
      done_owner <= link.rsp_need_owner;
      done_error <= link.rsp_error;
      done_owner_pe <= link.rsp_owner;
      done_state <= link.rsp_state;
    end
  end
endmodule : dir_remote

// ---- testbench/dir_chk.sv ----
module dir_chk (
  input wire logic ref_clk, // clock
  input wire logic rstn, // async reset
  input wire logic req_valid, // request
  input wire logic [1:0] req_op, // operation
  input wire logic req_ready, // request taken
  input wire logic rsp_valid, // answer
  input wire logic rsp_from_memory, // memory serves
  input wire logic rsp_need_owner, // owner supplies
  input wire logic rsp_error, // illegal state
  input wire logic [1:0] rsp_owner, // owner
  input wire logic [3:0] rsp_state // state seen
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic bad;
  logic modif;
  logic [1:0] own;
  // several mask bits beside the ownership bit have no meaning
  assign bad = rsp_state[0] && !$onehot0(rsp_state[3:1]);
  assign modif = rsp_state[0] && !bad;
  assign own = rsp_state[1] ? 2'h1 : rsp_state[2] ? 2'h2 : rsp_state[3] ? 2'h3 : 2'h0;
  sequence s_ans;
    rsp_valid;
  endsequence
  // answers to a read or an rfo, which may need the owner's data
  sequence s_read_ans;
    rsp_valid && ($past(req_op) == dir_pkg::OP_READ || $past(req_op) == dir_pkg::OP_READ_OWN);
  endsequence
  // answers to a castout or a done, which bring the data themselves
  sequence s_ret_ans;
    rsp_valid && ($past(req_op) == dir_pkg::OP_CASTOUT || $past(req_op) == dir_pkg::OP_OWNER_DONE);
  endsequence
  a_ready_high: assert property (req_ready)
    else $error("request refused");
  a_rsp_follows: assert property (req_valid |=> s_ans)
    else $error("request dropped");
  a_no_extra: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  a_one_path: assert property (s_ans |-> !(rsp_from_memory && rsp_need_owner))
    else $error("memory and owner both chosen");
  a_shared_mem: assert property (s_ans ##0 !rsp_state[0] |-> rsp_from_memory)
    else $error("shared granule not served by memory");
  a_mod_owner: assert property (s_read_ans ##0 modif |-> rsp_need_owner)
    else $error("modified granule read without owner");
  a_mod_no_mem: assert property (s_ans ##0 rsp_state[0] |-> !rsp_from_memory)
    else $error("modified granule served by memory");
  a_ret_no_owner: assert property (s_ret_ans |-> !rsp_need_owner)
    else $error("returning data asked of owner");
  a_illegal_flag: assert property (s_ans |-> rsp_error == bad)
    else $error("illegal state flag wrong");
  a_owner_decode: assert property (s_ans ##0 rsp_need_owner |-> rsp_owner == own)
    else $error("owner decode wrong");
endmodule : dir_chk

// ---- testbench/coherence_directory_state_bench.sv ----
module coherence_directory_state_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
  logic ref_clk = 0, rstn = 0, user_valid = 0, user_ready, done_valid, done_memory;
  logic done_owner, done_error, illegal_seen;
  logic load_valid = 1'h0;
  logic [3:0] load_addr = 4'h0, load_state = 4'h0;
  dir_pkg::op_type user_op = dir_pkg::OP_READ;
  logic [3:0] user_addr = 4'h0, done_state, busy_count;
  logic [1:0] user_pe = 2'h0, done_owner_pe;
  logic [3:0] mods [4] = '{4'h1, 4'h3, 4'h5, 4'h9};
  int errors = 0, cmp_count = 0;
  dir_if link (.ref_clk(ref_clk), .rstn(rstn)); // one hop, no loop
  dir_home dir_home_inst (.link(link.home), .load_valid(load_valid), .load_addr(load_addr),
    .load_state(load_state), .illegal_seen(illegal_seen), .busy_count(busy_count));
  dir_remote dir_remote_inst (.link(link.remote), .user_valid(user_valid), .user_op(user_op),
    .user_addr(user_addr), .user_pe(user_pe), .user_ready(user_ready), .done_valid(done_valid),
    .done_memory(done_memory), .done_owner(done_owner), .done_error(done_error),
    .done_owner_pe(done_owner_pe), .done_state(done_state));
  dir_chk dir_chk_inst (.ref_clk(ref_clk), .rstn(rstn), .req_valid(link.req_valid),
    .req_op(link.req_op),
    .req_ready(link.req_ready), .rsp_valid(link.rsp_valid), .rsp_from_memory(link.rsp_from_memory),
    .rsp_need_owner(link.rsp_need_owner), .rsp_error(link.rsp_error),
    .rsp_owner(link.rsp_owner), .rsp_state(link.rsp_state));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // one access; st is the state before it, f is {memory, owner, error} under mask mk
  task automatic access(input dir_pkg::op_type op, input logic [3:0] a, input logic [1:0] pe,
      input logic [3:0] st, input logic [2:0] f, input logic [2:0] mk = 3'h7);
    user_op = op;
    user_addr = a;
    user_pe = pe;
    user_valid = 1'b1;
    @(posedge ref_clk);
    #1 user_valid = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("done_valid", 1'b1, done_valid)
    `CHK("state", st, done_state)
    `CHK("flags", f, {done_memory, done_owner, done_error} & mk)
  endtask : access
  // writes one directory entry directly, then lets the next edge pass
  task automatic load(input logic [3:0] a, input logic [3:0] st);
    load_addr = a;
    load_state = st;
    load_valid = 1'b1;
    @(posedge ref_clk);
    #1 load_valid = 1'b0;
  endtask : load
  initial begin
    #200us;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    `CHK("ready", 1'b1, user_ready)
    access(dir_pkg::OP_READ, 4'h1, 2'h1, 4'h0, 3'h4);
    access(dir_pkg::OP_READ, 4'h1, 2'h2, 4'h2, 3'h4);
    access(dir_pkg::OP_READ, 4'h1, 2'h3, 4'h6, 3'h4);
    access(dir_pkg::OP_READ, 4'h1, 2'h0, 4'he, 3'h4);
    access(dir_pkg::OP_READ_OWN, 4'h1, 2'h3, 4'he, 3'h4);
    access(dir_pkg::OP_READ, 4'h1, 2'h1, 4'h9, 3'h2);
    `CHK("illegal_seen", 1'b0, illegal_seen)
    load(4'h2, 4'hf);
    access(dir_pkg::OP_READ, 4'h2, 2'h1, 4'hf, 3'h1);
    access(dir_pkg::OP_READ_OWN, 4'h2, 2'h1, 4'hf, 3'h1);
    `CHK("illegal_seen", 1'b1, illegal_seen)
    for (int p = 0; p < 4; p++) begin
      access(dir_pkg::OP_READ_OWN, 4'(4 + p), 2'(p), 4'h0, 3'h4);
      access(dir_pkg::OP_READ, 4'(4 + p), 2'(p + 1), mods[p], 3'h2);
      `CHK("owner", 2'(p), done_owner_pe)
    end
    // granules 1, 5, 6 and 7 are remotely modified; 2 is illegal, 4 local
    `CHK("busy_count", 4'h4, busy_count)
    // a waiting read-for-ownership must not take the granule before the castout lands
    access(dir_pkg::OP_READ_OWN, 4'h6, 2'h3, 4'h5, 3'h2);
    access(dir_pkg::OP_READ_OWN, 4'h6, 2'h3, 4'h5, 3'h2);
    access(dir_pkg::OP_CASTOUT, 4'h6, 2'h2, 4'h5, 3'h0, 3'h4);
    access(dir_pkg::OP_READ_OWN, 4'h6, 2'h3, 4'h0, 3'h4);
    access(dir_pkg::OP_OWNER_DONE, 4'h6, 2'h3, 4'h9, 3'h0, 3'h4);
    access(dir_pkg::OP_READ, 4'h6, 2'h1, 4'h8, 3'h4);
    `CHK("busy_count", 4'h3, busy_count)
    tally_and_finish();
  end
endmodule : coherence_directory_state_bench
